/* rtl/fifo_exp_dev.sv */
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module fifo_exp_dev (
    input wire logic pclk,
    input wire logic presetn,
    input wire fifo_exp_pkg::apb_req_s apb_req,
    output fifo_exp_pkg::apb_rsp_s apb_rsp,
    input wire logic write_en_n,
    input wire fifo_exp_pkg::word_t write_data_bus,
    input wire logic read_en_n,
    output fifo_exp_pkg::word_t read_data_bus,
    output fifo_exp_pkg::flags_s flags
);
    import fifo_exp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic mode_q;
    logic mode_cfg_q;
    logic mrst_q;
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] mem_cnt_q;
    logic [CNT_W-1:0] avail_q;
    logic wr_dly_q;
    logic pend_q;
    logic out_valid_q;
    logic full_n_q;
    logic ready_in_n_q;
    logic [31:0] prdata_q;
    logic wr_acc;
    logic rd_acc;
    logic pop;
    logic fetch;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic [CNT_W-1:0] level;
    word_t mem_rdata;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = p + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Handshake decode
    assign wr_acc = !write_en_n && full_n_q;
    assign pop = mode_q && !read_en_n && out_valid_q;
    assign rd_acc = !mode_q && !read_en_n && (avail_q != '0);
    // Fetch into the output stage only when it frees up
    assign fetch = mode_q && (avail_q != '0) && !pend_q && (!out_valid_q || pop); // R16
    assign level = mem_cnt_q + CNT_W'(pend_q) + CNT_W'(out_valid_q); // R11

    ////////////////////////////////////////////////////////////////////////
    // Storage
    fifo_word_mem u_mem (
        .pclk(pclk),
        .wr_en(wr_acc),
        .wr_addr(wr_ptr_q),
        .wr_data(write_data_bus),
        .rd_en(fetch || rd_acc),
        .rd_addr(rd_ptr_q),
        .rd_data_q(mem_rdata)
    );

    // Pointers and memory level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            mem_cnt_q <= '0;
        end else if (mrst_q) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            mem_cnt_q <= '0;
        end else begin
            if (wr_acc) begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (fetch || rd_acc) begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
            mem_cnt_q <= mem_cnt_q + CNT_W'(wr_acc) - CNT_W'(fetch || rd_acc);
        end
    end

    // Read-side view of written words, one cycle behind the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_dly_q <= 1'b0;
            avail_q <= '0;
        end else if (mrst_q) begin
            wr_dly_q <= 1'b0;
            avail_q <= '0;
        end else begin
            wr_dly_q <= wr_acc; // R3
            avail_q <= avail_q + CNT_W'(wr_dly_q) - CNT_W'(fetch || rd_acc);
        end
    end

    // Output stage; in fall-through mode a landed word drives output-ready low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
            out_valid_q <= 1'b0;
        end else if (mrst_q) begin
            pend_q <= 1'b0;
            out_valid_q <= 1'b0;
        end else begin
            pend_q <= fetch || rd_acc; // R14
            if (pend_q && mode_q) begin
                out_valid_q <= 1'b1; // R13
            end else if (pop) begin
                out_valid_q <= 1'b0;
            end
        end
    end

    // Output data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data_bus <= '0;
        end else if (pend_q) begin
            read_data_bus <= mem_rdata;
        end
    end

    // Write-side space flag; a freed slot shows next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_n_q <= 1'b0;
            ready_in_n_q <= 1'b1;
        end else if (mrst_q) begin
            full_n_q <= 1'b0;
            ready_in_n_q <= 1'b1;
        end else begin
            full_n_q <= 1'b1;
            ready_in_n_q <= 1'b0; // R18
            if ((mem_cnt_q + CNT_W'(wr_acc) - CNT_W'(fetch || rd_acc)) == CNT_W'(DEPTH)) begin
                full_n_q <= 1'b0;
                ready_in_n_q <= 1'b1;
            end
        end
    end

    // Flag outputs
    assign flags.empty_flag_n = (avail_q != '0); // R3
    assign flags.full_flag_n = full_n_q;
    assign flags.input_ready_n = ready_in_n_q; // R17
    assign flags.output_ready_n = !out_valid_q; // R13

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign apb_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign addr_ok = (apb_req.paddr == CTRL_ADDR) || (apb_req.paddr == STATUS_ADDR)
        || (apb_req.paddr == LEVEL_ADDR);
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok;
    assign apb_rsp.prdata = prdata_q;

    // Control register; master reset pulse loads the timing mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_cfg_q <= CTRL_MODE_RESET;
            mrst_q <= 1'b0;
            mode_q <= CTRL_MODE_RESET;
        end else begin
            mrst_q <= 1'b0;
            if (apb_wr && apb_req.paddr == CTRL_ADDR) begin
                mode_cfg_q <= apb_req.pwdata[CTRL_MODE_BIT];
                mrst_q <= apb_req.pwdata[CTRL_MRST_BIT];
            end
            if (mrst_q) begin
                mode_q <= mode_cfg_q;
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (apb_rd) begin
            prdata_q <= '0;
            case (apb_req.paddr)
                CTRL_ADDR: prdata_q[CTRL_MODE_BIT] <= mode_cfg_q;
                STATUS_ADDR: begin
                    prdata_q[ST_EMPTY_BIT] <= flags.empty_flag_n;
                    prdata_q[ST_FULL_BIT] <= flags.full_flag_n;
                    prdata_q[ST_IN_RDY_BIT] <= flags.input_ready_n;
                    prdata_q[ST_OUT_RDY_BIT] <= flags.output_ready_n;
                    prdata_q[ST_MODE_BIT] <= mode_q;
                end
                LEVEL_ADDR: prdata_q[CNT_W-1:0] <= level;
                default: prdata_q <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_empty_write;
        mode_q && level == '0 && wr_acc && !mrst_q;
    endsequence

    sequence s_ripple;
        flags.output_ready_n [*4] ##1 !flags.output_ready_n;
    endsequence

    a_first_word_latency: assert property (@(posedge pclk) disable iff (!presetn) // R14
        s_empty_write |-> s_ripple)
        else $error("first word not ready three cycles after write");

    a_ready_after_land: assert property (@(posedge pclk) disable iff (!presetn) // R13
        $fell(flags.output_ready_n) |-> $past(pend_q) && $past(mode_q))
        else $error("output-ready fell without a landed word");

    a_depth_sum: assert property (@(posedge pclk) disable iff (!presetn) // R11
        level <= CNT_W'(DEPTH + 1))
        else $error("level beyond device depth");

    a_no_added_delay: assert property (@(posedge pclk) disable iff (!presetn) // R16
        mode_q && pend_q && !mrst_q |=> !flags.output_ready_n)
        else $error("fetched word not presented next cycle");

    a_space_returns: assert property (@(posedge pclk) disable iff (!presetn) // R17
        mode_q && mem_cnt_q == CNT_W'(DEPTH) && fetch && !wr_acc && !mrst_q
        |=> !flags.input_ready_n)
        else $error("input-ready not low after slot freed");

    a_full_release: assert property (@(posedge pclk) disable iff (!presetn) // R18
        mode_q && level == CNT_W'(DEPTH + 1) && pop && !mrst_q
        |-> ##[1:4] !flags.input_ready_n)
        else $error("input-ready not low after read from full");

    a_empty_release: assert property (@(posedge pclk) disable iff (!presetn) // R3
        !mode_q && avail_q == '0 && wr_acc && !mrst_q
        |=> !flags.empty_flag_n ##1 flags.empty_flag_n)
        else $error("empty flag release not one cycle after write");

    a_full_blocks: assert property (@(posedge pclk) disable iff (!presetn) // R11
        mem_cnt_q == CNT_W'(DEPTH) |-> !flags.full_flag_n)
        else $error("full flag high with memory full");
endmodule

/* rtl/fifo_exp_pkg.sv */
// Behaviour
// R1 - Paralleled devices share write, read and control strobes; each has its data slice.
// R2 - Half-full and almost flags may come from one device, the main flags not.
// R3 - Empty/full release and ready assertion may lag one cycle between devices.
// R4 - Standard mode: composite empty and full flags are ANDs of active-low flags.
// R5 - Fall-through mode: composite ready flags are ORs of active-low ready flags.
// R6 - Flag and output control outputs of devices never wired together directly.
// R7 - Side-by-side devices have equal depth; word widths may differ.
// R8 - More parallel devices widen the word; buses concatenate the slices.
// R9 - Depth chains select fall-through mode at master reset on every device.
// R10 - In a chain, data outputs feed the next data inputs directly.
// R11 - Chain depth is the sum of device depths.
// R12 - Read clock of every chained device runs continuously.
// R13 - Valid word at outputs drives output-ready low; it writes the next device.
// R14 - First word reaches the outputs three cycles after its write.
// R15 - Latency budgets add cycles when clock skew minimum is missed.
// R16 - Only the first word into an empty chain sees the ripple latency.
// R17 - A freed location drives input-ready low so the previous device refills.
// R18 - After a read from full, input-ready goes low within per-device delay.
// R19 - Transfer clock tied to the faster of write and read clocks.
// R20 - Wrapper parameterised by device count and width generates flags and handshakes.
package fifo_exp_pkg;
    localparam int DATA_W = 18;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int FIRST_WORD_CYCLES = 3;
    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] LEVEL_ADDR = 8'h08;
    // Control fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_MRST_BIT = 1;
    localparam logic CTRL_MODE_RESET = 1'b0;
    // Status fields
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_IN_RDY_BIT = 2;
    localparam int ST_OUT_RDY_BIT = 3;
    localparam int ST_MODE_BIT = 4;

    typedef logic [DATA_W-1:0] word_t;

    typedef struct packed {
        logic empty_flag_n;
        logic full_flag_n;
        logic input_ready_n;
        logic output_ready_n;
    } flags_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
endpackage

/* rtl/fifo_word_mem.sv */
`timescale 1ns/1ns
module fifo_word_mem (
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [fifo_exp_pkg::PTR_W-1:0] wr_addr,
    input wire fifo_exp_pkg::word_t wr_data,
    input wire logic rd_en,
    input wire logic [fifo_exp_pkg::PTR_W-1:0] rd_addr,
    output fifo_exp_pkg::word_t rd_data_q
);
    import fifo_exp_pkg::*;

    word_t mem [DEPTH];

    // Storage write
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge pclk) begin
        if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule

/* testbench/fifo_exp_dev_tb.sv */
`timescale 1ns/1ns
module fifo_exp_dev_tb;
    import fifo_exp_pkg::*;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_s apb_req = '0;
    apb_rsp_s apb_rsp;
    logic write_en_n = 1'b1;
    word_t write_data_bus = '0;
    logic read_en_n;
    word_t read_data_bus;
    flags_s flags;
    logic [7:0] limit = 8'h00;
    logic ft_mode = 1'b0;
    logic [7:0] count_q;
    logic seq_ok_q;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;

    fifo_exp_dev u_fifo_exp_dev (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .write_en_n(write_en_n), .write_data_bus(write_data_bus),
        .read_en_n(read_en_n), .read_data_bus(read_data_bus), .flags(flags));
    fifo_reader_model u_fifo_reader_model (.pclk(pclk), .presetn(presetn),
        .std_mode(!ft_mode), .limit(limit), .empty_flag_n(flags.empty_flag_n),
        .output_ready_n(flags.output_ready_n), .read_data_bus(read_data_bus),
        .read_en_n(read_en_n), .count_q(count_q), .seq_ok_q(seq_ok_q));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            stop_test();
        end
    end

    task stop_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer, launched and released right after rising edges
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1) @(posedge pclk);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    // Back-to-back words first..first+n-1, driven at rising edges
    task put(input int first, input int n);
        @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            write_en_n <= 1'b0;
            write_data_bus <= word_t'(first + i);
            @(posedge pclk);
        end
        write_en_n <= 1'b1;
    endtask

    task tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        `CHK("or_idle", 1'b1, flags.output_ready_n)
        `CHK("inrdy_idle", 1'b0, flags.input_ready_n)
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        `CHK("status", 32'h0000_000a, rd)
        apb(1'b0, 8'h0c, 32'h0000_0000);
        `CHK("bad_err", 1'b1, err)
        `CHK("bad_data", 32'h0000_0000, rd)
        // Standard mode: empty flag releases one edge after the write edge
        put(1, 1);
        tick(0);
        `CHK("empty_early", 1'b0, flags.empty_flag_n)
        tick(1);
        `CHK("empty_rise", 1'b1, flags.empty_flag_n)
        // Standard-mode read; data two edges after the take
        limit <= 8'd1;
        tick(6);
        `CHK("std_count", 8'd1, count_q)
        `CHK("std_data", word_t'(1), read_data_bus)
        `CHK("empty_after", 1'b0, flags.empty_flag_n)
        // Master reset into fall-through mode
        apb(1'b1, CTRL_ADDR, 32'h0000_0003);
        ft_mode <= 1'b1;
        tick(2);
        apb(1'b0, STATUS_ADDR, 32'h0000_0000);
        `CHK("mode", 1'b1, rd[ST_MODE_BIT])
        `CHK("or_clr", 1'b1, rd[ST_OUT_RDY_BIT])
        // First word appears three edges after its write
        put(2, 1);
        tick(2);
        `CHK("or_early", 1'b1, flags.output_ready_n)
        tick(1);
        `CHK("or_first", 1'b0, flags.output_ready_n)
        `CHK("data_first", word_t'(2), read_data_bus)
        // Fill to memory plus output stage, then a refused write
        put(3, 16);
        tick(3);
        `CHK("full", 1'b0, flags.full_flag_n)
        `CHK("inrdy_full", 1'b1, flags.input_ready_n)
        put(99, 1);
        apb(1'b0, LEVEL_ADDR, 32'h0000_0000);
        `CHK("level_full", 32'h0000_0011, rd)
        // One pop frees a place within a bounded delay
        limit <= 8'd2;
        while (count_q !== 8'd2) @(posedge pclk);
        tick(4);
        `CHK("inrdy_back", 1'b0, flags.input_ready_n)
        // Drain all in order
        limit <= 8'd18;
        while (count_q !== 8'd18) @(posedge pclk);
        tick(4);
        `CHK("or_drain", 1'b1, flags.output_ready_n)
        apb(1'b0, LEVEL_ADDR, 32'h0000_0000);
        `CHK("level_empty", 32'h0000_0000, rd)
        // Second word follows the first with no ripple delay
        limit <= 8'd20;
        put(19, 2);
        tick(10);
        `CHK("follow", 8'd20, count_q)
        `CHK("order", 1'b1, seq_ok_q)
        stop_test();
    end
endmodule

/* testbench/fifo_reader_model.sv */
`timescale 1ns/1ns
module fifo_reader_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic std_mode,
    input wire logic [7:0] limit,
    input wire logic empty_flag_n,
    input wire logic output_ready_n,
    input wire fifo_exp_pkg::word_t read_data_bus,
    output logic read_en_n,
    output logic [7:0] count_q,
    output logic seq_ok_q
);
    import fifo_exp_pkg::*;
    logic avail;
    logic pop;
    logic chk;
    logic [2:0] pipe_q;
    logic [7:0] chk_cnt_q;

    // Word visible to the reader in either timing mode
    assign avail = std_mode ? empty_flag_n : !output_ready_n;
    // Word leaves the device at this edge
    assign pop = !read_en_n && avail;
    // Standard-mode data stands two edges after the take
    assign chk = std_mode ? pipe_q[2] : pop;
    ////////////////////////////////////////////////////////////////////////////////
    // Pop request, evaluated every cycle like a free-running read clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_en_n <= 1'b1;
        end else begin
            read_en_n <= !(((count_q + 8'(pop)) < limit) && avail);
        end
    end

    // Count of words taken; words carry their position counted from one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 8'h00;
            chk_cnt_q <= 8'h00;
            pipe_q <= 3'h0;
            seq_ok_q <= 1'b1;
        end else begin
            count_q <= count_q + 8'(pop);
            chk_cnt_q <= chk_cnt_q + 8'(chk);
            pipe_q <= {pipe_q[1:0], pop && std_mode};
            seq_ok_q <= seq_ok_q && (!chk || read_data_bus == word_t'(chk_cnt_q + 8'h01));
        end
    end
endmodule
